// ### verilog/iop_top.sv
// i/o port block: two ports behind an axi4-lite register slave, with the
// alternate-function overrides of port b pins 0 and 1
// assumes: pin inputs synchronous to aclk; external pad applies oe/pull-up
//
// What this block does
// - programmed clock-out fuse overrides pb1 pull-up, direction, value with clock
// - pb1 direction overridden by clock out, compare a, or serial master clock
// - pb1 input enable overridden by pin change group 1, analog disable, irq0
// - pb1 input enable forced true by pin change group 1 or irq0
// - pb0 only input-enable overrides: pin change group 1 or analog disable
// - port a level register at 0x00 returns the eight pin levels
// - port a direction at 0x01, eight read/write bits, reset 0x00
// - port a output value at 0x02, eight read/write bits, reset zero
// - port a pull-up enable at 0x03, eight read/write bits, reset zero
// - port b registers 0x04 to 0x07 implement bits 3:0 only
// - switching control at 0x16: bit 1 port b, bit 0 port a
// - port b break-before-make bit applies to every port b pin except pb1 while its direction is overridden
// - port a break-before-make bit applies to every port a pin
// - with break-before-make, new outputs stay tristate one cycle first
`include "iop_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module iop_top
#(
	parameter int PA_W = 8,
	parameter int PB_W = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`IOP_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`IOP_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [PA_W-1:0] pa_pin_in,
	output logic [PA_W-1:0] pa_pin_out,
	output logic [PA_W-1:0] pa_pin_oe,
	output logic [PA_W-1:0] pa_pullup_en,
	input wire logic [PB_W-1:0] pb_pin_in,
	output logic [PB_W-1:0] pb_pin_out,
	output logic [PB_W-1:0] pb_pin_oe,
	output logic [PB_W-1:0] pb_pullup_en,
	input wire logic sysclk_pin_output,
	input wire logic compare_a_output,
	input wire logic serial_clock_out_value
);

	if (PA_W < 1 || PA_W > 8)
	begin : g_bad_pa
		$error("iop_top: PA_W must be 1 to 8");
	end
	if (PB_W < 2 || PB_W > 8)
	begin : g_bad_pb
		$error("iop_top: PB_W must be 2 to 8");
	end

	// index of a word address, or all ones when unaligned
	function automatic logic [5:0] word_index(
		input logic [`IOP_ADDR_W-1:0] addr
	);
		if (addr[`IOP_ADDR_LSB-1:0] != '0)
			word_index = 6'h3f;
		else
			word_index = addr[`IOP_ADDR_W-1:`IOP_ADDR_LSB];
	endfunction

	function automatic logic is_mapped(input logic [5:0] idx);
		unique case (idx)
			`IOP_IDX_PA_LEVELS, `IOP_IDX_PA_DIR, `IOP_IDX_PA_OUT,
			`IOP_IDX_PA_PUE, `IOP_IDX_PB_LEVELS, `IOP_IDX_PB_DIR,
			`IOP_IDX_PB_OUT, `IOP_IDX_PB_PUE, `IOP_IDX_SWITCHING,
			`IOP_IDX_ALT_CTL, `IOP_IDX_ALT_STATUS:
				is_mapped = 1'b1;
			default:
				is_mapped = 1'b0;
		endcase
	endfunction

	// write channel holding
	logic aw_held;
	logic [`IOP_ADDR_W-1:0] aw_addr;
	logic w_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [5:0] wr_idx;
	logic wr_lo;

	// registers
	logic [`IOP_SWITCHING_W-1:0] port_switching_control;
	iop_pkg::iop_alt_ctl_t alt_ctl;

	// port state from the two port controllers
	logic [PA_W-1:0] pa_dir;
	logic [PA_W-1:0] pa_out;
	logic [PA_W-1:0] pa_pue;
	logic [PA_W-1:0] pa_levels;
	logic [PA_W-1:0] pa_drive;
	logic [PB_W-1:0] pb_dir;
	logic [PB_W-1:0] pb_out;
	logic [PB_W-1:0] pb_pue;
	logic [PB_W-1:0] pb_levels;
	logic [PB_W-1:0] pb_drive;
	logic [PB_W-1:0] pb_in_en;

	iop_pkg::iop_override_t ov_pb0;
	iop_pkg::iop_override_t ov_pb1;
	logic sysclk_pin_output_on;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_idx = word_index(aw_addr);
	assign wr_lo = do_write && w_strb[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (do_write)
			w_held <= 1'b0;
	end

	// unmapped or unaligned writes are dropped and answered with slverr
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `IOP_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(wr_idx) ? `IOP_RESP_OKAY
				: `IOP_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			port_switching_control <= `IOP_SWITCHING_RESET;
		else if (wr_lo && wr_idx == `IOP_IDX_SWITCHING)
			port_switching_control <= w_data[`IOP_SWITCHING_W-1:0];
	end

	// fuse and peripheral enables; byte lane 1 holds the top two bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			alt_ctl <= `IOP_ALT_CTL_RESET;
		else if (do_write && wr_idx == `IOP_IDX_ALT_CTL)
		begin
			if (w_strb[0])
				alt_ctl[7:0] <= w_data[7:0];
			if (w_strb[1])
				alt_ctl[`IOP_ALT_CTL_W-1:8] <= w_data[`IOP_ALT_CTL_W-1:8];
		end
	end

	iop_port_ctl #(
		.W(PA_W)
	) u_port_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_dir(wr_lo && wr_idx == `IOP_IDX_PA_DIR),
		.wr_out(wr_lo && wr_idx == `IOP_IDX_PA_OUT),
		.wr_pue(wr_lo && wr_idx == `IOP_IDX_PA_PUE),
		.wr_levels(wr_lo && wr_idx == `IOP_IDX_PA_LEVELS),
		.wdata(w_data[PA_W-1:0]),
		.bbm(port_switching_control[`IOP_BBM_A_BIT]),
		.pin_in(pa_pin_in),
		.in_en({PA_W{1'b1}}),
		.dir(pa_dir),
		.out_val(pa_out),
		.pue(pa_pue),
		.levels(pa_levels),
		.drive_en(pa_drive)
	);

	iop_port_ctl #(
		.W(PB_W)
	) u_port_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_dir(wr_lo && wr_idx == `IOP_IDX_PB_DIR),
		.wr_out(wr_lo && wr_idx == `IOP_IDX_PB_OUT),
		.wr_pue(wr_lo && wr_idx == `IOP_IDX_PB_PUE),
		.wr_levels(wr_lo && wr_idx == `IOP_IDX_PB_LEVELS),
		.wdata(w_data[PB_W-1:0]),
		.bbm(port_switching_control[`IOP_BBM_B_BIT]),
		.pin_in(pb_pin_in),
		.in_en(pb_in_en),
		.dir(pb_dir),
		.out_val(pb_out),
		.pue(pb_pue),
		.levels(pb_levels),
		.drive_en(pb_drive)
	);

	// fuse bit reads 0 when programmed
	assign sysclk_pin_output_on = !alt_ctl.clock_out_fuse;

	always_comb
	begin
		ov_pb1.pullup_override_en = sysclk_pin_output_on;
		ov_pb1.direction_override_en = sysclk_pin_output_on
			|| (alt_ctl.compare_a_enable && !alt_ctl.alt_location_select)
			|| alt_ctl.serial_clock_master_sel;
		// the three sources are exclusive by the fuse and alt_location_select terms;
		// a clock on the pin needs a steady driver, so the fuse term is
		// the enable itself and the toggling rides on the value path
		ov_pb1.direction_override_val = sysclk_pin_output_on
			|| (!sysclk_pin_output_on && alt_ctl.compare_a_enable
				&& !alt_ctl.alt_location_select && compare_a_output)
			|| (!sysclk_pin_output_on && (!alt_ctl.compare_a_enable
				|| alt_ctl.alt_location_select)
				&& alt_ctl.serial_clock_master_sel
				&& serial_clock_out_value);
		ov_pb1.value_override_en = sysclk_pin_output_on;
		ov_pb1.value_override_val = sysclk_pin_output;
		ov_pb1.input_en_override_en = (alt_ctl.pin_change_src_nine
			&& alt_ctl.pin_change_group1_en)
			|| alt_ctl.analog5_digital_disable
			|| alt_ctl.ext_irq_zero_sel;
		ov_pb1.input_en_override_val = (alt_ctl.pin_change_src_nine
			&& alt_ctl.pin_change_group1_en)
			|| alt_ctl.ext_irq_zero_sel;
	end

	always_comb
	begin
		ov_pb0.pullup_override_en = 1'b0;
		ov_pb0.direction_override_en = 1'b0;
		ov_pb0.direction_override_val = 1'b0;
		ov_pb0.value_override_en = 1'b0;
		ov_pb0.value_override_val = 1'b0;
		ov_pb0.input_en_override_en = (alt_ctl.pin_change_src_eight
			&& alt_ctl.pin_change_group1_en)
			|| alt_ctl.analog4_digital_disable;
		ov_pb0.input_en_override_val = alt_ctl.pin_change_src_eight
			&& alt_ctl.pin_change_group1_en;
	end

	// port a has no overrides here
	assign pa_pin_out = pa_out;
	assign pa_pin_oe = pa_drive;
	assign pa_pullup_en = pa_pue & ~pa_dir;

	// port b: pins 0 and 1 pass through their override sets
	always_comb
	begin
		pb_pin_out = pb_out;
		pb_pin_oe = pb_drive;
		pb_pullup_en = pb_pue & ~pb_dir;
		pb_in_en = '1;
		if (ov_pb0.pullup_override_en)
			pb_pullup_en[0] = 1'b0;
		if (ov_pb0.direction_override_en)
			pb_pin_oe[0] = ov_pb0.direction_override_val;
		if (ov_pb0.value_override_en)
			pb_pin_out[0] = ov_pb0.value_override_val;
		if (ov_pb0.input_en_override_en)
			pb_in_en[0] = ov_pb0.input_en_override_val;
		// a peripheral that takes the direction over also decides the pull-up
		if (ov_pb1.direction_override_en)
		begin
			pb_pin_oe[1] = ov_pb1.direction_override_val;
			pb_pullup_en[1] = pb_pue[1]
				&& !ov_pb1.direction_override_val;
		end
		if (ov_pb1.pullup_override_en)
			pb_pullup_en[1] = 1'b0;
		if (ov_pb1.value_override_en)
			pb_pin_out[1] = ov_pb1.value_override_val;
		if (ov_pb1.input_en_override_en)
			pb_in_en[1] = ov_pb1.input_en_override_val;
	end

	// read mux; the level registers show sampled pins, not stored values
	function automatic logic [31:0] read_word(input logic [5:0] idx);
		read_word = '0;
		unique case (idx)
			`IOP_IDX_PA_LEVELS:
				read_word[PA_W-1:0] = pa_levels;
			`IOP_IDX_PA_DIR:
				read_word[PA_W-1:0] = pa_dir;
			`IOP_IDX_PA_OUT:
				read_word[PA_W-1:0] = pa_out;
			`IOP_IDX_PA_PUE:
				read_word[PA_W-1:0] = pa_pue;
			`IOP_IDX_PB_LEVELS:
				read_word[PB_W-1:0] = pb_levels;
			`IOP_IDX_PB_DIR:
				read_word[PB_W-1:0] = pb_dir;
			`IOP_IDX_PB_OUT:
				read_word[PB_W-1:0] = pb_out;
			`IOP_IDX_PB_PUE:
				read_word[PB_W-1:0] = pb_pue;
			`IOP_IDX_SWITCHING:
				read_word[`IOP_SWITCHING_W-1:0] = port_switching_control;
			`IOP_IDX_ALT_CTL:
				read_word[`IOP_ALT_CTL_W-1:0] = alt_ctl;
			`IOP_IDX_ALT_STATUS:
				read_word[5:0] = {pb_in_en[1:0], pb_pin_oe[1:0],
					ov_pb1.direction_override_en,
					ov_pb1.value_override_en};
			default:
				read_word = '0;
		endcase
	endfunction

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `IOP_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word(word_index(s_axi_araddr));
			s_axi_rresp <= is_mapped(word_index(s_axi_araddr))
				? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule // iop_top

`default_nettype wire

// ### verilog/iop_cfg.svh
// register indices, field positions, reset values for the i/o port block
// assumes: included by bare name from package and design files
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH

// register indices; byte address on the bus is four times the index
`define IOP_IDX_PA_LEVELS 6'h00
`define IOP_IDX_PA_DIR 6'h01
`define IOP_IDX_PA_OUT 6'h02
`define IOP_IDX_PA_PUE 6'h03
`define IOP_IDX_PB_LEVELS 6'h04
`define IOP_IDX_PB_DIR 6'h05
`define IOP_IDX_PB_OUT 6'h06
`define IOP_IDX_PB_PUE 6'h07
`define IOP_IDX_SWITCHING 6'h16
`define IOP_IDX_ALT_CTL 6'h20
`define IOP_IDX_ALT_STATUS 6'h21

// bus address width and the two low bits that select a byte
`define IOP_ADDR_W 8
`define IOP_ADDR_LSB 2

// reset values
`define IOP_DIR_RESET 8'h00
`define IOP_OUT_RESET 8'h00
`define IOP_PUE_RESET 8'h00
`define IOP_SWITCHING_RESET 2'h0
// clock-out fuse reads 1 (unprogrammed) after reset
`define IOP_ALT_CTL_RESET 10'h001

// port switching control fields
`define IOP_BBM_A_BIT 0
`define IOP_BBM_B_BIT 1
`define IOP_SWITCHING_W 2

// alternate-function control width
`define IOP_ALT_CTL_W 10

// axi response codes
`define IOP_RESP_OKAY 2'h0
`define IOP_RESP_SLVERR 2'h2

`endif

// ### verilog/iop_pkg.sv
// types for the i/o port block
// assumes: iop_cfg.svh supplies the field widths
`include "iop_cfg.svh"

package iop_pkg;

	// alternate-function control, software-written
	typedef struct packed {
		logic ext_irq_zero_sel;
		logic analog5_digital_disable;
		logic analog4_digital_disable;
		logic pin_change_group1_en;
		logic pin_change_src_nine;
		logic pin_change_src_eight;
		logic serial_clock_master_sel;
		logic alt_location_select;
		logic compare_a_enable;
		logic clock_out_fuse;
	} iop_alt_ctl_t;

	// override set for one pin
	typedef struct packed {
		logic pullup_override_en;
		logic direction_override_en;
		logic direction_override_val;
		logic value_override_en;
		logic value_override_val;
		logic input_en_override_en;
		logic input_en_override_val;
	} iop_override_t;

endpackage

// ### verilog/iop_port_ctl.sv
// one port's direction, output value and pull-up registers, the
// break-before-make gap, and the sampled pin levels
// assumes: strobes are single-cycle pulses from the bus slave
`include "iop_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module iop_port_ctl
#(
	parameter int W = 8
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_dir,
	input wire logic wr_out,
	input wire logic wr_pue,
	input wire logic wr_levels,
	input wire logic [W-1:0] wdata,
	input wire logic bbm,
	input wire logic [W-1:0] pin_in,
	input wire logic [W-1:0] in_en,
	output logic [W-1:0] dir,
	output logic [W-1:0] out_val,
	output logic [W-1:0] pue,
	output logic [W-1:0] levels,
	output logic [W-1:0] drive_en
);

	logic [W-1:0] gap;

	if (W < 1 || W > 8)
	begin : g_bad_width
		$error("iop_port_ctl: W must be 1 to 8");
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			dir <= W'(`IOP_DIR_RESET);
		else if (wr_dir)
			dir <= wdata;
	end

	// a write of one to a level bit flips the output value
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			out_val <= W'(`IOP_OUT_RESET);
		else if (wr_out)
			out_val <= wdata;
		else if (wr_levels)
			out_val <= out_val ^ wdata;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pue <= W'(`IOP_PUE_RESET);
		else if (wr_pue)
			pue <= wdata;
	end

	// bits newly turned to output stay tristate for one cycle
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			gap <= '0;
		else if (wr_dir && bbm)
			gap <= wdata & ~dir;
		else
			gap <= '0;
	end

	// disabled digital inputs read as zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			levels <= '0;
		else
			levels <= pin_in & in_en;
	end

	assign drive_en = dir & ~gap;

endmodule // iop_port_ctl

`default_nettype wire

// ### verification/iop_board.sv
// pad model for one port: a driven pad shows the pin value, else the
// pull-up, else whatever the board puts on it
// assumes: the bench supplies the board level of undriven pads
`timescale 1ns/100ps
`default_nettype none
module iop_board
#(
	parameter int W = 8
)
(
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	input wire logic [W-1:0] pullup_en,
	input wire logic [W-1:0] ext_level,
	output logic [W-1:0] pin_in
);
	always_comb
	begin
		for (int i = 0; i < W; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] :
				(pullup_en[i] ? 1'b1 : ext_level[i]);
	end
endmodule // iop_board
`default_nettype wire

// ### verification/iop_top_sva.sv
// port-level checker for iop_top
// assumes: bound to every iop_top instance, one clock domain
`timescale 1ns/100ps
`default_nettype none
module iop_top_sva
#(
	parameter int PA_W = 8,
	parameter int PB_W = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [PA_W-1:0] pa_pin_out,
	input wire logic [PA_W-1:0] pa_pin_oe,
	input wire logic [PA_W-1:0] pa_pullup_en,
	input wire logic [PB_W-1:0] pb_pin_oe,
	input wire logic [PB_W-1:0] pb_pullup_en
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken during response");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken during response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
	a_pa_pull_input: assert property ((pa_pullup_en & pa_pin_oe) == '0) else $error("pull-up on driven pin a");
	a_pb_pull_input: assert property ((pb_pullup_en & pb_pin_oe) == '0) else $error("pull-up on driven pin b");
	a_pa_out_write: assert property ($changed(pa_pin_out) |-> $rose(s_axi_bvalid)) else $error("pin a value moved without write");
	a_pa_oe_write: assert property (|(pa_pin_oe & ~$past(pa_pin_oe)) |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("pin a drive without write");
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	c_pa_drive: cover property ($rose(|pa_pin_oe));
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // iop_top_sva
bind iop_top iop_top_sva #(.PA_W(PA_W), .PB_W(PB_W)) u_sva (.aclk, .aresetn,
	.s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.pa_pin_out, .pa_pin_oe, .pa_pullup_en, .pb_pin_oe, .pb_pullup_en);
`default_nettype wire

// ### verification/io_port_regs_and_pb_override_test.sv
// self-checking bench for iop_top: registers, pins, overrides, break gap
// assumes: iop_board models the pads, iop_top_sva is bound to the design
`include "iop_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module io_port_regs_and_pb_override_test;
	logic aclk = 0, aresetn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [7:0] pa_pin_in, pa_pin_out, pa_pin_oe, pa_pullup_en, ext_a = 0, oe_a;
	logic [3:0] pb_pin_in, pb_pin_out, pb_pin_oe, pb_pullup_en, ext_b = 0, oe_b;
	logic sysclk_pin_output = 0, compare_a_output = 0, serial_clock_out_value = 0;
	logic [31:0] seed = 32'h39690262;
	int err_count = 0, checked = 0, cycles = 0;
	// lazy: raise bready/rready only once the answer is seen
	logic lazy = 0;
	always #12.5 aclk = ~aclk;
	// clock seen as data: toggles every cycle
	always @(posedge aclk) sysclk_pin_output <= ~sysclk_pin_output;
	iop_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pa_pin_in, .pa_pin_out, .pa_pin_oe, .pa_pullup_en,
		.pb_pin_in, .pb_pin_out, .pb_pin_oe, .pb_pullup_en, .sysclk_pin_output,
		.compare_a_output, .serial_clock_out_value);
	iop_board #(.W(8)) u_pa (.pin_out(pa_pin_out), .pin_oe(pa_pin_oe),
		.pullup_en(pa_pullup_en), .ext_level(ext_a), .pin_in(pa_pin_in));
	iop_board #(.W(4)) u_pb (.pin_out(pb_pin_out), .pin_oe(pb_pin_oe),
		.pullup_en(pb_pullup_en), .ext_level(ext_b), .pin_in(pb_pin_in));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] ad(input int i);
		return 8'(i * 4);
	endfunction
	function automatic logic [7:0] lvl(input logic [7:0] oe, o, p, e);
		return (oe & o) | (~oe & p) | (~oe & ~p & e);
	endfunction
	task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t resp %h exp %h", $time, got, exp);
		end
	endtask
	// readies are looked at on the falling edge: settled, and equal to what
	// the next rising edge samples since inputs only move on rising edges
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_ok, w_ok, b_ok, bv, br;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= !lazy;
		br = !lazy;
		do
		begin
			@(negedge aclk);
			aw_ok = s_axi_awready;
			w_ok = s_axi_wready;
			bv = s_axi_bvalid;
			b_ok = bv && br;
			r = s_axi_bresp;
			oe_a = pa_pin_oe;
			oe_b = pb_pin_oe;
			@(posedge aclk);
			if (aw_ok)
				s_axi_awvalid <= 1'b0;
			if (w_ok)
				s_axi_wvalid <= 1'b0;
			if (bv && !br)
			begin
				s_axi_bready <= 1'b1;
				br = 1'b1;
			end
		end
		while (!b_ok);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_ok, got, rv, rr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !lazy;
		rr = !lazy;
		do
		begin
			@(negedge aclk);
			ar_ok = s_axi_arready;
			rv = s_axi_rvalid;
			got = rv && rr;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar_ok)
				s_axi_arvalid <= 1'b0;
			if (rv && !rr)
			begin
				s_axi_rready <= 1'b1;
				rr = 1'b1;
			end
		end
		while (!got);
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rs);
		cmp_resp(rs, `IOP_RESP_OKAY);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a, rd_d, rs);
		cmp_resp(rs, `IOP_RESP_OKAY);
		cmp_data(rd_d, exp);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	initial
	begin
		logic [7:0] d [8];
		logic [9:0] ie_alt [3];
		logic [3:0] ie_exp [3];
		ie_alt = '{10'h181, 10'h1f1, 10'h381};
		ie_exp = '{4'hc, 4'hf, 4'he};
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 1; i < 8; i++)
			if (i != 4)
				rd(ad(i), 0);
		rd(ad(`IOP_IDX_SWITCHING), 0);
		rd(ad(`IOP_IDX_ALT_CTL), 1);
		$display("test reset done");
		for (int n = 0; n < 16; n++)
		begin
			for (int i = 1; i < 8; i++)
			begin
				seed = nx(seed);
				d[i] = seed[7:0] & (i < 4 ? 8'hff : 8'h0f);
				if (i != 4)
					wr(ad(i), seed);
			end
			ext_a <= seed[15:8];
			ext_b <= seed[19:16];
			lazy = seed[20] | (n == 0);
			for (int i = 1; i < 8; i++)
				if (i != 4)
					rd(ad(i), d[i]);
			cmp_data(32'(pa_pin_oe), d[1]);
			cmp_data(32'(pa_pin_out), d[2]);
			cmp_data(32'(pa_pullup_en), d[3] & ~d[1]);
			cmp_data(32'(pb_pin_oe), d[5]);
			cmp_data(32'(pb_pin_out), d[6]);
			cmp_data(32'(pb_pullup_en), d[7] & ~d[5]);
			rd(ad(0), lvl(d[1], d[2], d[3], ext_a));
			rd(ad(4), lvl(d[5], d[6], d[7], {4'h0, ext_b}));
		end
		lazy = 1'b0;
		// ones written to the level register flip the output value
		wr(ad(0), 32'h5a);
		rd(ad(2), d[2] ^ 8'h5a);
		// without the low byte strobe the write is dropped
		s_axi_wstrb <= 4'he;
		wr(ad(2), 32'h0);
		s_axi_wstrb <= 4'hf;
		rd(ad(2), d[2] ^ 8'h5a);
		$display("test random registers done");
		axi_wr(8'h40, 32'h1, rs);
		cmp_resp(rs, `IOP_RESP_SLVERR);
		axi_rd(8'h05, rd_d, rs);
		cmp_resp(rs, `IOP_RESP_SLVERR);
		cmp_data(rd_d, 0);
		wr(ad(`IOP_IDX_SWITCHING), 32'hff);
		rd(ad(`IOP_IDX_SWITCHING), 3);
		for (int s = 0; s < 4; s++)
		begin
			wr(ad(`IOP_IDX_SWITCHING), s);
			wr(ad(1), 0);
			wr(ad(5), 0);
			wr(ad(1), 8'hff);
			cmp_data(32'(oe_a), s[0] ? 0 : 8'hff);
			wr(ad(5), 4'hf);
			cmp_data(32'(oe_b), s[1] ? 0 : 4'hf);
			cmp_data(32'(pa_pin_oe), 8'hff);
		end
		$display("test break gap done");
		wr(ad(5), 0);
		wr(ad(7), 4'hf);
		wr(ad(`IOP_IDX_ALT_CTL), 0);
		repeat (4)
		begin
			@(negedge aclk);
			cmp_data({pb_pin_oe[1], pb_pullup_en[1], pb_pin_out[1]},
				{2'b10, sysclk_pin_output});
		end
		rd(ad(`IOP_IDX_ALT_STATUS), 32'h3b);
		for (int i = 0; i < 4; i++)
		begin
			wr(ad(`IOP_IDX_ALT_CTL), i[1] ? 32'h9 : 32'h3);
			@(posedge aclk);
			compare_a_output <= i[0];
			serial_clock_out_value <= ~i[0];
			@(negedge aclk);
			cmp_data(32'(pb_pin_oe[1]), i[1] ^ i[0]);
		end
		for (int i = 0; i < 3; i++)
		begin
			wr(ad(`IOP_IDX_ALT_CTL), 32'(ie_alt[i]));
			repeat (3) @(posedge aclk);
			rd(ad(4), 32'(ie_exp[i]));
		end
		$display("test overrides done");
		report_and_stop();
	end
endmodule // io_port_regs_and_pb_override_test
`default_nettype wire
